// ---- core/nce_consts.svh ----
// register map, field positions, opcodes and reset values of the core
`ifndef NCE_CONSTS_SVH
`define NCE_CONSTS_SVH
// apb register byte offsets
`define NCE_REG_EXEC      8'h00
`define NCE_REG_STATUS    8'h04
`define NCE_REG_PC        8'h08
`define NCE_REG_PORT      8'h0C
`define NCE_REG_MADDR     8'h10
`define NCE_REG_MDATA     8'h14
// field positions in the status word
`define NCE_ST_ACC        0
`define NCE_ST_LOW        4
`define NCE_ST_HIGH       8
`define NCE_ST_CF         12
`define NCE_ST_SLF        13
`define NCE_ST_PA         16
`define NCE_ST_PB         20
`define NCE_ST_RBANK      24
// field positions in the pc word
`define NCE_PC_RPC        8
`define NCE_PC_SLF        16
// field positions in the port word
`define NCE_PT_AUX        4
`define NCE_PT_P3         8
`define NCE_PT_P2         16
// output bit that steers the input path
`define NCE_P2_INSEL      13
// fixed opcodes
`define NCE_OP_CMP_LE     8'h01
`define NCE_OP_ADD_MEM    8'h06
`define NCE_OP_INC_L      8'h05
`define NCE_OP_IN         8'h08
`define NCE_OP_FLIP_H     8'h09
`define NCE_OP_OUT        8'h0A
`define NCE_OP_CLR_P2     8'h0C
`define NCE_OP_SET_P2     8'h0D
`define NCE_OP_CMP_NZ     8'h0E
`define NCE_OP_RET        8'h0F
`define NCE_OP_SUB_MEM    8'h3C
`define NCE_OP_NEG        8'h3D
`define NCE_OP_INC_MEM    8'h3E
`define NCE_OP_INC_A      8'h70
`define NCE_OP_DEC_A      8'h77
`define NCE_OP_CLR_A      8'h7F
// reset values
`define NCE_RST_CF        1'b1
`define NCE_RST_WORD      32'h0000_0000
`endif

// ---- core/nce_pkg.sv ----
// types shared by the nibble execution core
package nce_pkg;
   // apb request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } nce_apb_req_t;
   // apb answer to the master
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } nce_apb_rsp_t;
   // carry-and-sum of a nibble operation
   typedef struct packed {
      logic       carry;
      logic [3:0] sum;
   } nce_sum_t;
endpackage

// ---- core/nce_core.sv ----
// nibble execution core with apb register access and port logic
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "nce_consts.svh"

module nce_core #(
   parameter int MEM_AW = 7
) (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // apb slave
   input  wire nce_pkg::nce_apb_req_t apb_req,
   output nce_pkg::nce_apb_rsp_t      apb_rsp,
   // input pins
   input  wire logic [3:0]            key_input_nibble,
   input  wire logic [1:0]            aux_input_pair,
   // output pins
   output logic      [15:0]           single_bit_outputs,
   output logic      [4:0]            nibble_output_reg
);
   import nce_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // nibble add with carry out, wraps modulo sixteen
   function automatic nce_sum_t nib_add(input logic [3:0] a,
                                        input logic [3:0] b);
      logic [4:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state

   logic [3:0]        acc_q;
   logic [3:0]        acc_d;
   logic [3:0]        low_q;
   logic [3:0]        low_d;
   logic [2:0]        high_q;
   logic [2:0]        high_d;
   logic              condition_flag_q;
   logic              condition_flag_d;
   logic              secondary_latch_flag_q;
   logic [3:0]        active_bank_reg_q;
   logic [3:0]        active_bank_reg_d;
   logic [3:0]        bank_buffer_reg_q;
   logic [3:0]        bank_buffer_reg_d;
   logic [3:0]        return_bank_slot_q;
   logic [3:0]        return_bank_slot_d;
   logic [5:0]        pc_q;
   logic [5:0]        pc_d;
   logic [5:0]        ret_pc_q;
   logic [5:0]        ret_pc_d;
   logic [15:0]       p2_d;
   logic [4:0]        p3_d;
   logic [7:0]        op_q;
   logic [MEM_AW-1:0] maddr_q;
   logic [3:0]        mem [0:(1<<MEM_AW)-1];

   // input synchronisers and agreed values
   logic [5:0]        in_s1_q;
   logic [5:0]        in_s2_q;
   logic [5:0]        in_s3_q;
   logic [5:0]        in_filt_q;

   ////////////////////////////////////////////////////////////////////////
   // apb decode

   wire       acc_phase  = apb_req.psel & apb_req.penable;
   wire       take       = acc_phase & apb_rsp.pready;
   wire       wr_take    = take & apb_req.pwrite;
   wire [7:0] a          = apb_req.paddr;
   wire       hit_exec   = (a == `NCE_REG_EXEC);
   wire       hit_status = (a == `NCE_REG_STATUS);
   wire       hit_pc     = (a == `NCE_REG_PC);
   wire       hit_port   = (a == `NCE_REG_PORT);
   wire       hit_maddr  = (a == `NCE_REG_MADDR);
   wire       hit_mdata  = (a == `NCE_REG_MDATA);
   wire       hit_any    = hit_exec | hit_status | hit_pc | hit_port |
                           hit_maddr | hit_mdata;
   wire       exec_go    = wr_take & hit_exec;

   // operand fetch and input selection
   wire [7:0]        op       = apb_req.pwdata[7:0];
   wire [MEM_AW-1:0] hl_addr  = MEM_AW'({high_q, low_q});
   wire [3:0]        mem_nib  = mem[hl_addr];
   wire [3:0]        key_nib  = in_filt_q[3:0];
   wire [1:0]        aux_pair = in_filt_q[5:4];
   wire              use_key  = ~single_bit_outputs[`NCE_P2_INSEL];
   wire [3:0]        in_sel   = use_key ? key_nib
                                        : {2'b00, aux_pair};

   // opcode groups with operand fields
   wire is_jump  = (op[7:6] == 2'b10);
   wire is_call  = (op[7:6] == 2'b11);
   wire is_page  = (op[7:4] == 4'h1);
   wire is_ld_l  = (op[7:4] == 4'h4);
   wire is_ld_h  = (op[7:3] == 5'b00101);
   wire is_tbit  = (op[7:2] == 6'b001110);
   wire is_addi  = (op[7:4] == 4'h7);
   wire [5:0] pc_inc = pc_q + 6'd1;

   // shared arithmetic results
   nce_sum_t add_mem;
   nce_sum_t add_imm;
   nce_sum_t inc_mem;
   nce_sum_t inc_low;
   nce_sum_t inc_acc;
   nce_sum_t dec_acc;
   nce_sum_t neg_acc;
   assign add_mem = nib_add(acc_q, mem_nib);
   assign add_imm = nib_add(acc_q, op[3:0]);
   assign inc_mem = nib_add(mem_nib, 4'h1);
   assign inc_low = nib_add(low_q, 4'h1);
   assign inc_acc = nib_add(acc_q, 4'h1);
   assign dec_acc = nib_add(acc_q, 4'hF);
   assign neg_acc = nib_add(~acc_q, 4'h1);
   wire [4:0] sub_mem = {1'b0, mem_nib} - {1'b0, acc_q};

   ////////////////////////////////////////////////////////////////////////
   // instruction effects

   // next state for the opcode on the exec write
   always_comb begin
      acc_d              = acc_q;
      low_d              = low_q;
      high_d             = high_q;
      condition_flag_d   = 1'b1;
      active_bank_reg_d  = active_bank_reg_q;
      bank_buffer_reg_d  = bank_buffer_reg_q;
      return_bank_slot_d = return_bank_slot_q;
      ret_pc_d           = ret_pc_q;
      pc_d               = pc_inc;
      p2_d               = single_bit_outputs;
      p3_d               = nibble_output_reg;
      case (op)
         `NCE_OP_CMP_LE: begin
            condition_flag_d = (acc_q <= mem_nib);
         end
         `NCE_OP_CMP_NZ: begin
            condition_flag_d = (in_sel != 4'h0);
         end
         `NCE_OP_RET: begin
            pc_d              = ret_pc_q;
            bank_buffer_reg_d = return_bank_slot_q;
            active_bank_reg_d = return_bank_slot_q;
         end
         `NCE_OP_SET_P2: begin
            p2_d[low_q] = 1'b1;
         end
         `NCE_OP_CLR_P2: begin
            p2_d[low_q] = 1'b0;
         end
         `NCE_OP_IN: begin
            acc_d = in_sel;
         end
         `NCE_OP_OUT: begin
            p3_d = {secondary_latch_flag_q, acc_q};
         end
         `NCE_OP_NEG: begin
            acc_d            = neg_acc.sum;
            condition_flag_d = (neg_acc.sum == 4'h0);
         end
         `NCE_OP_FLIP_H: begin
            high_d[2] = ~high_q[2];
         end
         `NCE_OP_CLR_A: begin
            acc_d = 4'h0;
         end
         `NCE_OP_ADD_MEM: begin
            acc_d            = add_mem.sum;
            condition_flag_d = add_mem.carry;
         end
         `NCE_OP_SUB_MEM: begin
            acc_d            = sub_mem[3:0];
            condition_flag_d = ~sub_mem[4];
         end
         `NCE_OP_INC_MEM: begin
            acc_d            = inc_mem.sum;
            condition_flag_d = inc_mem.carry;
         end
         `NCE_OP_INC_L: begin
            low_d            = inc_low.sum;
            condition_flag_d = inc_low.carry;
         end
         `NCE_OP_INC_A: begin
            acc_d            = inc_acc.sum;
            condition_flag_d = 1'b1;
         end
         `NCE_OP_DEC_A: begin
            acc_d            = dec_acc.sum;
            condition_flag_d = dec_acc.carry;
         end
         default: begin
            if (is_jump) begin
               if (condition_flag_q) begin
                  pc_d              = op[5:0];
                  active_bank_reg_d = bank_buffer_reg_q;
               end
            end else if (is_call) begin
               if (condition_flag_q) begin
                  ret_pc_d           = pc_inc;
                  return_bank_slot_d = active_bank_reg_q;
                  pc_d               = op[5:0];
                  active_bank_reg_d  = bank_buffer_reg_q;
               end
            end else if (is_tbit) begin
               condition_flag_d = mem_nib[op[1:0]];
            end else if (is_page) begin
               bank_buffer_reg_d = op[3:0];
            end else if (is_ld_l) begin
               low_d = op[3:0];
            end else if (is_ld_h) begin
               high_d = op[2:0];
            end else if (is_addi) begin
               acc_d            = add_imm.sum;
               condition_flag_d = add_imm.carry;
            end else begin
               condition_flag_d = condition_flag_q;
            end
         end
      endcase
   end

   // architectural registers, updated once per executed opcode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q              <= 4'h0;
         low_q              <= 4'h0;
         high_q             <= 3'h0;
         condition_flag_q   <= `NCE_RST_CF;
         active_bank_reg_q  <= 4'h0;
         bank_buffer_reg_q  <= 4'h0;
         return_bank_slot_q <= 4'h0;
         ret_pc_q           <= 6'h00;
         single_bit_outputs <= 16'h0000;
         nibble_output_reg  <= 5'h00;
         op_q               <= 8'h00;
      end else if (exec_go) begin
         acc_q              <= acc_d;
         low_q              <= low_d;
         high_q             <= high_d;
         condition_flag_q   <= condition_flag_d;
         active_bank_reg_q  <= active_bank_reg_d;
         bank_buffer_reg_q  <= bank_buffer_reg_d;
         return_bank_slot_q <= return_bank_slot_d;
         ret_pc_q           <= ret_pc_d;
         single_bit_outputs <= p2_d;
         nibble_output_reg  <= p3_d;
         op_q               <= op;
      end
   end

   // program counter: opcode advance or software load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_q <= 6'h00;
      end else if (exec_go) begin
         pc_q <= pc_d;
      end else if (wr_take && hit_pc) begin
         pc_q <= apb_req.pwdata[5:0];
      end
   end

   // secondary flag is written only by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         secondary_latch_flag_q <= 1'b0;
      end else if (wr_take && hit_pc) begin
         secondary_latch_flag_q <= apb_req.pwdata[`NCE_PC_SLF];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // data memory window

   // memory address pointer for software access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         maddr_q <= '0;
      end else if (wr_take && hit_maddr) begin
         maddr_q <= apb_req.pwdata[MEM_AW-1:0];
      end
   end

   // memory written only through the window, never by opcodes here
   always_ff @(posedge pclk) begin
      if (wr_take && hit_mdata) begin
         mem[maddr_q] <= apb_req.pwdata[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // input pins

   // three-stage synchroniser, value accepted when stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_s1_q   <= 6'h00;
         in_s2_q   <= 6'h00;
         in_s3_q   <= 6'h00;
         in_filt_q <= 6'h00;
      end else begin
         in_s1_q <= {aux_input_pair, key_input_nibble};
         in_s2_q <= in_s1_q;
         in_s3_q <= in_s2_q;
         if (in_s2_q == in_s3_q) begin
            in_filt_q <= in_s3_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb read data and answer

   wire [31:0] st_word = {4'h0, return_bank_slot_q, bank_buffer_reg_q,
                          active_bank_reg_q, 2'b00, secondary_latch_flag_q,
                          condition_flag_q, 1'b0, high_q, low_q, acc_q};
   wire [31:0] pc_word = {15'h0000, secondary_latch_flag_q, 2'b00,
                          ret_pc_q, 2'b00, pc_q};
   wire [31:0] pt_word = {single_bit_outputs, 3'b000, nibble_output_reg,
                          2'b00, aux_pair, key_nib};
   wire [31:0] rd_word = hit_exec   ? {24'h00_0000, op_q} :
                         hit_status ? st_word :
                         hit_pc     ? pc_word :
                         hit_port   ? pt_word :
                         hit_maddr  ? 32'(maddr_q) :
                         hit_mdata  ? {28'h000_0000, mem[maddr_q]} :
                                      `NCE_RST_WORD;

   // one wait state: ready rises on the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_rsp <= '0;
      end else if (acc_phase && !apb_rsp.pready) begin
         apb_rsp.pready  <= 1'b1;
         apb_rsp.pslverr <= ~hit_any;
         apb_rsp.prdata  <= apb_req.pwrite ? `NCE_RST_WORD : rd_word;
      end else begin
         apb_rsp <= '0;
      end
   end

endmodule

// ---- verification/nce_checker.sv ----
// port-level assertions for the nibble execution core
`timescale 1ns/100ps
`include "nce_consts.svh"
module nce_checker (
   // clock and reset
   input wire logic                  pclk,
   input wire logic                  presetn,
   // apb slave side
   input wire nce_pkg::nce_apb_req_t apb_req,
   input wire nce_pkg::nce_apb_rsp_t apb_rsp,
   // pins
   input wire logic [3:0]            key_input_nibble,
   input wire logic [1:0]            aux_input_pair,
   input wire logic [15:0]           single_bit_outputs,
   input wire logic [4:0]            nibble_output_reg
);
   import nce_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////
   // taken exec writes and mapped offsets
   wire logic [7:0]  op = apb_req.pwdata[7:0];
   wire logic        ex = apb_req.psel & apb_req.penable & apb_rsp.pready
                          & apb_req.pwrite & (apb_req.paddr == `NCE_REG_EXEC);
   wire logic        mp = (apb_req.paddr[1:0] == 2'b00)
                          && (apb_req.paddr <= `NCE_REG_MDATA);
   wire logic [15:0] sb = single_bit_outputs;
   ////////////////////////////////////////////////////////////////////////
   a_one_wait: assert property (apb_req.psel && !apb_req.penable
      |=> !apb_rsp.pready ##1 apb_rsp.pready)
      else $error("pready not in second access cycle");
   a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready longer than one cycle");
   a_idle_quiet: assert property (!apb_rsp.pready
      |-> apb_rsp.prdata == 32'h0000_0000 && !apb_rsp.pslverr)
      else $error("answer fields busy without pready");
   a_err_unmapped: assert property (apb_rsp.pready && !mp
      |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   a_ok_mapped: assert property (apb_rsp.pready && mp |-> !apb_rsp.pslverr)
      else $error("mapped access refused");
   a_set_rises: assert property (ex && op == `NCE_OP_SET_P2
      |=> (($past(sb) & ~sb) == 16'h0000)
          && ($countones(sb ^ $past(sb)) <= 1))
      else $error("set opcode changed more than one bit");
   a_clr_falls: assert property (ex && op == `NCE_OP_CLR_P2
      |=> ((~$past(sb) & sb) == 16'h0000)
          && ($countones(sb ^ $past(sb)) <= 1))
      else $error("clear opcode changed more than one bit");
   a_bits_hold: assert property (!(ex && (op == `NCE_OP_SET_P2
      || op == `NCE_OP_CLR_P2)) |=> $stable(sb))
      else $error("single bit outputs moved without opcode");
   a_out_hold: assert property (!(ex && op == `NCE_OP_OUT)
      |=> $stable(nibble_output_reg))
      else $error("nibble output moved without opcode");
endmodule

bind nce_core nce_checker i_chk (
   .pclk               (pclk),
   .presetn            (presetn),
   .apb_req            (apb_req),
   .apb_rsp            (apb_rsp),
   .key_input_nibble   (key_input_nibble),
   .aux_input_pair     (aux_input_pair),
   .single_bit_outputs (single_bit_outputs),
   .nibble_output_reg  (nibble_output_reg)
);

// ---- verification/nce_pin_env.sv ----
// input pin model standing for the key nibble and aux pair lines
`timescale 1ns/100ps
module nce_pin_env (
   // levels the bench asks for
   input  wire logic [3:0] key_lvl,
   input  wire logic [1:0] aux_lvl,
   // pins into the core
   output logic      [3:0] key_input_nibble,
   output logic      [1:0] aux_input_pair
);
   // switches hold their level, no pull or float on these inputs
   assign key_input_nibble = key_lvl;
   assign aux_input_pair   = aux_lvl;
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the nibble execution core
`timescale 1ns/100ps
`include "nce_consts.svh"
module tb;
   import nce_pkg::*;
   logic          pclk = 1'b0;
   logic          presetn = 1'b0;
   nce_apb_req_t  req = '0;
   nce_apb_rsp_t  rsp;
   logic [3:0]    key_lvl = 4'h0;
   logic [1:0]    aux_lvl = 2'h0;
   logic [3:0]    key_pin;
   logic [1:0]    aux_pin;
   logic [15:0]   sbo;
   logic [4:0]    nout;
   logic [31:0]   rd;
   logic          er;
   int            n_fail = 0;
   int            checked = 0;
   ////////////////////////////////////////////////////////////////////////
   // clock
   always #5 pclk = ~pclk;
   nce_pin_env i_pins (.key_lvl(key_lvl), .aux_lvl(aux_lvl),
      .key_input_nibble(key_pin), .aux_input_pair(aux_pin));
   nce_core i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
      .apb_rsp(rsp), .key_input_nibble(key_pin), .aux_input_pair(aux_pin),
      .single_bit_outputs(sbo), .nibble_output_reg(nout));
   ////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task summarize();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // compare one value
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   // one apb transfer, held until pready is seen or 50 access cycles pass, then the run ends failed
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      req.psel <= 1'b1;
      req.pwrite <= w;
      req.paddr <= a;
      req.pwdata <= d;
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 50);
      rd = rsp.prdata;
      er = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      if (n >= 50) begin
         chk("pready", 32'h0000_0001, 32'h0000_0000);
         summarize();
      end
      @(negedge pclk);
   endtask
   // read and compare under a mask
   task rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
            input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, e, rd & m);
   endtask
   // execute one opcode
   task ex(input logic [7:0] op);
      apb(1'b1, `NCE_REG_EXEC, {24'h00_0000, op});
   endtask
   // accumulator and condition flag
   task st(input logic [3:0] acc, input logic cf);
      rdc("status", `NCE_REG_STATUS, 32'h0000_100F, {19'h0, cf, 8'h00, acc});
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdc("reset", `NCE_REG_STATUS, 32'hFFFF_FFFF, 32'h0000_1000);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk("slverr", 32'h1, {31'h0, er});
      chk("errdata", 32'h0, rd);
      apb(1'b1, `NCE_REG_MADDR, 32'h0000_0003);
      apb(1'b1, `NCE_REG_MDATA, 32'h0000_0008);
      ex(8'h43);
      ex(8'h7F); st(4'h0, 1'b1);
      ex(8'h79); st(4'h9, 1'b0);
      ex(8'h01); st(4'h9, 1'b0);
      ex(8'h06); st(4'h1, 1'b1);
      ex(8'h01); st(4'h1, 1'b1);
      ex(8'h3C); st(4'h7, 1'b1);
      ex(8'h72); ex(8'h3C); st(4'hF, 1'b0);
      ex(8'h3E); st(4'h9, 1'b0);
      ex(8'h3D); st(4'h7, 1'b0);
      ex(8'h7F); ex(8'h3D); st(4'h0, 1'b1);
      ex(8'h77); st(4'hF, 1'b0);
      ex(8'h70); st(4'h0, 1'b1);
      rdc("mem", `NCE_REG_MDATA, 32'h0000_000F, 32'h0000_0008);
      for (int i = 0; i < 4; i++) begin
         ex(8'h38 + 8'(i)); st(4'h0, i == 3);
      end
      ex(8'h4F); ex(8'h05);
      rdc("low", `NCE_REG_STATUS, 32'h0000_10F0, 32'h0000_1000);
      ex(8'h05);
      rdc("low", `NCE_REG_STATUS, 32'h0000_10F0, 32'h0000_0010);
      ex(8'h2C); ex(8'h09);
      rdc("high", `NCE_REG_STATUS, 32'h0000_1700, 32'h0000_1000);
      ex(8'h09);
      rdc("high", `NCE_REG_STATUS, 32'h0000_1700, 32'h0000_1400);
      ex(8'h4D); ex(8'h0D); chk("p2", 32'h0000_2000, {16'h0, sbo});
      ex(8'h45); ex(8'h0D); chk("p2", 32'h0000_2020, {16'h0, sbo});
      ex(8'h4D); ex(8'h0C); chk("p2", 32'h0000_0020, {16'h0, sbo});
      @(posedge pclk);
      key_lvl <= 4'h5;
      aux_lvl <= 2'h2;
      repeat (8) @(posedge pclk);
      ex(8'h08); st(4'h5, 1'b1);
      ex(8'h0D); ex(8'h08); st(4'h2, 1'b1);
      ex(8'h0C);
      @(posedge pclk);
      key_lvl <= 4'h0;
      repeat (8) @(posedge pclk);
      ex(8'h0E); st(4'h2, 1'b0);
      @(posedge pclk);
      key_lvl <= 4'h5;
      repeat (8) @(posedge pclk);
      ex(8'h0E); st(4'h2, 1'b1);
      apb(1'b1, `NCE_REG_PC, 32'h0001_0000);
      ex(8'h0A); chk("p3", 32'h0000_0012, {27'h0, nout});
      rdc("slf", `NCE_REG_PC, 32'h0001_0000, 32'h0001_0000);
      ex(8'h13); ex(8'h7F); ex(8'hAA);
      rdc("jpc", `NCE_REG_PC, 32'h0000_003F, 32'h0000_002A);
      rdc("jbank", `NCE_REG_STATUS, 32'h00FF_1000, 32'h0033_1000);
      ex(8'h71); ex(8'h85);
      rdc("npc", `NCE_REG_PC, 32'h0000_003F, 32'h0000_002C);
      st(4'h1, 1'b1);
      ex(8'h16); ex(8'hC5);
      rdc("cpc", `NCE_REG_PC, 32'h0000_3F3F, 32'h0000_2E05);
      rdc("cbank", `NCE_REG_STATUS, 32'h0FFF_1000, 32'h0366_1000);
      ex(8'h17); ex(8'h0F);
      rdc("rpc", `NCE_REG_PC, 32'h0000_003F, 32'h0000_002E);
      rdc("rbank", `NCE_REG_STATUS, 32'h0FFF_1000, 32'h0333_1000);
      ex(8'h71); ex(8'hC5); st(4'h2, 1'b1);
      rdc("ncpc", `NCE_REG_PC, 32'h0000_3F3F, 32'h0000_2E30);
      rdc("port", `NCE_REG_PORT, 32'hFFFF_FFFF, 32'h0020_1225);
      summarize();
   end
endmodule
